// >>> event_flag_bank.sv
// Bank of sticky flags in which a set always beats a clear
`timescale 1ns/1ps
`include "wake_ctl_params.svh"

module event_flag_bank #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Flag control
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  // Flag state
  output logic [W-1:0] flags_out
);

  logic [W-1:0] flags_d;

  // Set wins so an event in the clear cycle is never lost
  always_comb begin
    flags_d = (flags_out & ~clr_in) | set_in;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_out <= '0;
    end else begin
      flags_out <= flags_d;
    end
  end

endmodule

// >>> testbench.sv
// Self-checking bench for the wake register block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
  fails++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module testbench;
  import wake_ctl_pkg::*;
  logic core_clk_in;
  logic rst_n_in;
  logic host_sw_reset_in;
  host_bus_req_t host_req;
  proc_bus_req_t proc_req;
  wake_events_t ev;
  logic [7:0] hrd, erd, q, m;
  logic smi_n, irq;
  int fails = 0;
  int n_tests = 0;
  logic [7:0] eofs[8] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h0A, 8'h0C,
    8'h0E, 8'h10};
  logic [4:0] hofs[4] = '{5'h00, 5'h07, 5'h13, 5'h15};
  int bit_pos[3] = '{0, 1, 3};
  // Event levels: module, call, call mode, second_n, first_n
  wake_events_t act[3] = '{5'b00110, 5'b00101, 5'b01111};
  wake_event_acpi_request_regs u_wake_event_acpi_request_regs (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .host_sw_reset_in(host_sw_reset_in), .host_req_in(host_req),
    .host_rdata_out(hrd), .proc_req_in(proc_req), .proc_rdata_out(erd),
    .events_in(ev), .system_mgmt_irq_n_out(smi_n), .wake_irq_out(irq));
  wake_host_model u_wake_host_model (.core_clk_in(core_clk_in),
    .host_req_out(host_req), .proc_req_out(proc_req),
    .host_rdata_in(hrd), .proc_rdata_in(erd));
  ////////////////////
  // Access helpers over the partner model
  task automatic hw(input logic [4:0] a, input logic [7:0] d);
    u_wake_host_model.host_acc(1'b1, a, d, q);
  endtask
  task automatic hr(input logic [4:0] a, input logic [7:0] e);
    u_wake_host_model.host_acc(1'b0, a, 8'h00, q);
    `CHK("host read", e, q)
  endtask
  task automatic ew(input logic [15:0] a, input logic [7:0] d);
    u_wake_host_model.proc_acc(1'b1, a, d, q);
  endtask
  task automatic er(input logic [15:0] a, input logic [7:0] e);
    u_wake_host_model.proc_acc(1'b0, a, 8'h00, q);
    `CHK("proc read", e, q)
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////
  // Clock, 4 ns period
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    fails++;
    stop_test();
  end
  // Main sequence
  initial begin
    rst_n_in = 1'b0;
    host_sw_reset_in = 1'b0;
    ev = 5'b00111;
    repeat (16) @(posedge core_clk_in);
    #1 rst_n_in = 1'b1;
    foreach (hofs[i]) hr(hofs[i], 8'h00);
    foreach (eofs[i]) er({8'h14, eofs[i]}, 8'h00);
    for (int i = 2; i < 8; i++) ew({8'h14, eofs[i]}, 8'hA5);
    for (int i = 2; i < 8; i++) er({8'h14, eofs[i]}, 8'hA5);
    ew(16'h0408, 8'h5A);
    er(16'h1408, 8'hA5);
    er(16'h1508, 8'h00);
    hr(5'h08, 8'h00);
    hw(5'h13, 8'hFF);
    hr(5'h13, 8'hCB);
    hw(5'h15, 8'hFF);
    hr(5'h15, 8'hCB);
    // Sleep requests reach the processor mirror but never read back
    hw(5'h07, 8'hFF);
    hr(5'h07, 8'h00);
    er(16'h1402, 8'h3E);
    ew(16'h1402, 8'h3E);
    er(16'h1402, 8'h00);
    hw(5'h07, 8'hC1);
    er(16'h1402, 8'h01);
    // Each event routed by its own mask bit only; outputs read settled
    foreach (bit_pos[i]) begin
      m = 8'h01 << bit_pos[i];
      hw(5'h13, m);
      hw(5'h15, 8'hCB ^ m);
      ev = act[i];
      repeat (3) @(posedge core_clk_in);
      #1;
      `CHK("smi on", 1'b0, smi_n)
      `CHK("irq off", 1'b0, irq)
      hw(5'h13, 8'hCB ^ m);
      hw(5'h15, m);
      repeat (3) @(posedge core_clk_in);
      #1;
      `CHK("smi off", 1'b1, smi_n)
      `CHK("irq on", 1'b1, irq)
      hr(5'h00, m);
      ev = 5'b00111;
      hw(5'h00, m);
      hr(5'h00, 8'h00);
      repeat (2) @(posedge core_clk_in);
      #1;
      `CHK("irq clr", 1'b0, irq)
    end
    // Software event toggles on and off by host writes
    hw(5'h13, 8'h40);
    hw(5'h15, 8'h40);
    hw(5'h00, 8'h40);
    repeat (3) @(posedge core_clk_in);
    #1;
    `CHK("soft smi", 1'b0, smi_n)
    `CHK("soft irq", 1'b1, irq)
    hw(5'h00, 8'h40);
    hr(5'h00, 8'h00);
    // Set mode: host writes only set, the processor retires the event
    ew(16'h1400, 8'h20);
    hw(5'h00, 8'h40);
    hw(5'h00, 8'h40);
    hr(5'h00, 8'h40);
    ew(16'h140E, 8'h40);
    hr(5'h00, 8'h00);
    hw(5'h00, 8'h40);
    repeat (3) @(posedge core_clk_in);
    #1;
    `CHK("set smi", 1'b0, smi_n)
    // Host software reset clears both masks and the live flag
    @(posedge core_clk_in);
    #1 host_sw_reset_in = 1'b1;
    @(posedge core_clk_in);
    #1 host_sw_reset_in = 1'b0;
    hr(5'h13, 8'h00);
    hr(5'h15, 8'h00);
    hr(5'h00, 8'h00);
    `CHK("smi reset", 1'b1, smi_n)
    // Mask bit 7 is storage only: the module event reaches no output
    ev = 5'b10111;
    hw(5'h13, 8'h80);
    hw(5'h15, 8'h80);
    repeat (3) @(posedge core_clk_in);
    #1;
    `CHK("module smi", 1'b1, smi_n)
    `CHK("module irq", 1'b0, irq)
    hr(5'h00, 8'h80);
    // Call detect with its mode off never raises a flag
    ev = 5'b01011;
    hw(5'h00, 8'h80);
    hr(5'h00, 8'h00);
    stop_test();
  end
endmodule
bind wake_event_acpi_request_regs wake_regs_props u_wake_regs_props (
  .core_clk_in, .rst_n_in, .host_sw_reset_in, .host_req_in,
  .host_rdata_out, .proc_req_in, .proc_rdata_out, .system_mgmt_irq_n_out,
  .wake_irq_out);

// >>> wake_ctl_params.svh
// Offsets, field positions, reset values and base address of the wake block
`ifndef WAKE_CTL_PARAMS_SVH
`define WAKE_CTL_PARAMS_SVH

// Host view offsets
`define HOST_WAKE_STATUS_OFS 5'h00
`define HOST_SLEEP_REQ_OFS 5'h07
`define HOST_SMI_EN_OFS 5'h13
`define HOST_IRQ_EN_OFS 5'h15

// Controller view base and offsets
`define PROC_BASE_ADDR 16'h1400
`define PROC_CS1_OFS 5'h00
`define PROC_CS2_OFS 5'h02
`define PROC_CS3_OFS 5'h04
`define PROC_BASE_LO_OFS 5'h08
`define PROC_BASE_HI_OFS 5'h0A
`define PROC_CIER_OFS 5'h0C
`define PROC_HSTAT_OFS 5'h0E
`define PROC_HIER_OFS 5'h10

// Field positions
`define SOFT_EVENT_BIT 6
`define CALL_DETECT_BIT 3
`define SECOND_IND_BIT 1
`define FIRST_IND_BIT 0
`define MODULE_EVENT_BIT 7
`define CLEAR_MODE_BIT 5

// Writable masks
`define EVENT_BITS_MASK 8'hCB
`define SLEEP_REQ_MASK 8'h3E
// Event bits that may reach the outputs; mask bit 7 is storage only
`define ROUTE_BITS_MASK 8'h4B

// Reset values
`define REG_RESET 8'h00
`define FLAG_RESET 8'h00

`endif

// >>> wake_ctl_pkg.sv
// Types shared by the wake block, its host model and its checks
package wake_ctl_pkg;

  // Host register port, one access per strobe
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } host_bus_req_t;

  // Embedded processor register port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } proc_bus_req_t;

  // Raw wake event levels
  typedef struct packed {
    logic module_event;
    logic call_detect;
    logic call_detect_mode;
    logic second_call_indicator_n;
    logic first_call_indicator_n;
  } wake_events_t;

  // Register state of the top module
  typedef struct packed {
    logic [7:0] smi_en;
    logic [7:0] irq_en;
    logic [7:0] req;
    logic [7:0] cs1;
    logic [7:0] cs3;
    logic [7:0] base_lo;
    logic [7:0] base_hi;
    logic [7:0] cier;
    logic [7:0] hstat;
    logic [7:0] hier;
    logic [7:0] host_rdata;
    logic [7:0] proc_rdata;
    logic smi_n;
    logic irq;
  } wake_regs_t;

endpackage

// >>> wake_event_acpi_request_regs.sv
// Wake event, sleep request and enable registers with both register views
//
// Contract
// - Reading the sleep-state request register always returns zero.
// - Bits 5..1 of the request register are host request flags, reset 0.
// - Bits 7, 6 and 0 of the request register are reserved, read as zero.
// - SMI mask bits 6, 3, 1, 0 route soft, call, second, first events.
// - Interrupt mask uses the same bits to route events to the interrupt.
// - Both masks clear at power-up and at a host software reset.
// - Mask bits 5..4 and 2 read zero; bit 7 is a plain read/write bit.
// - Controller registers answer only the processor port, based at 1400h.
// - Controller map is 00h, 02h, 04h, 08h, 0Ah, 0Ch, 0Eh and 10h.
// - Event status flags 7, 3, 1, 0 are set by active events and cleared by writing 1.
// - Mirror flags copy sleep requests; a zero request sets the S0 flag.
`timescale 1ns/1ps
`include "wake_ctl_params.svh"

module wake_event_acpi_request_regs (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic host_sw_reset_in,
  // Host register port
  input wire wake_ctl_pkg::host_bus_req_t host_req_in,
  output logic [7:0] host_rdata_out,
  // Embedded processor register port
  input wire wake_ctl_pkg::proc_bus_req_t proc_req_in,
  output logic [7:0] proc_rdata_out,
  // Wake events
  input wire wake_ctl_pkg::wake_events_t events_in,
  // Wake outputs
  output logic system_mgmt_irq_n_out,
  output logic wake_irq_out
);
  import wake_ctl_pkg::*;

  wake_regs_t regs_q;
  wake_regs_t regs_d;
  logic [7:0] status_flags;
  logic [7:0] status_set;
  logic [7:0] status_clr;
  logic [5:0] mirror_flags;
  logic [5:0] mirror_set;
  logic [5:0] mirror_clr;
  logic proc_hit;
  logic [4:0] proc_ofs;
  logic host_wr_status;
  logic host_wr_req;
  logic proc_wr_cs2;
  logic proc_wr_hstat;
  logic clear_mode;
  logic [7:0] host_rd_mux;
  logic [7:0] proc_rd_mux;
  localparam logic [15:0] PROC_BASE = `PROC_BASE_ADDR;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Only the processor port sees the 1400h window; the host never reaches it
  assign proc_hit = (proc_req_in.addr[15:5] == PROC_BASE[15:5]);
  assign proc_ofs = proc_req_in.addr[4:0];
  assign host_wr_status = host_req_in.wr &&
                          (host_req_in.addr == `HOST_WAKE_STATUS_OFS);
  assign host_wr_req = host_req_in.wr &&
                       (host_req_in.addr == `HOST_SLEEP_REQ_OFS);
  assign proc_wr_cs2 = proc_req_in.wr && proc_hit &&
                       (proc_ofs == `PROC_CS2_OFS);
  assign proc_wr_hstat = proc_req_in.wr && proc_hit &&
                         (proc_ofs == `PROC_HSTAT_OFS);
  assign clear_mode = regs_q.cs1[`CLEAR_MODE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Wake event status flags

  // Events set flags while active; write-one clears; soft bit has two modes
  always_comb begin
    status_set = 8'h00;
    status_clr = 8'h00;
    status_set[`MODULE_EVENT_BIT] = events_in.module_event;
    status_set[`CALL_DETECT_BIT] = events_in.call_detect &&
                                   events_in.call_detect_mode;
    status_set[`SECOND_IND_BIT] = !events_in.second_call_indicator_n;
    status_set[`FIRST_IND_BIT] = !events_in.first_call_indicator_n;
    if (host_wr_status) begin
      status_clr = host_req_in.wdata & `EVENT_BITS_MASK;
      status_clr[`SOFT_EVENT_BIT] = 1'b0;
      if (host_req_in.wdata[`SOFT_EVENT_BIT]) begin
        // Toggle mode flips the bit, set mode only ever sets it
        if (clear_mode || !status_flags[`SOFT_EVENT_BIT]) begin
          status_set[`SOFT_EVENT_BIT] = 1'b1;
        end else begin
          status_clr[`SOFT_EVENT_BIT] = 1'b1;
        end
      end
    end
    // In set mode the processor retires the soft event
    if (proc_wr_hstat && clear_mode &&
        proc_req_in.wdata[`SOFT_EVENT_BIT]) begin
      status_clr[`SOFT_EVENT_BIT] = 1'b1;
    end
    // A mode-off call detector holds its flag at zero
    if (!events_in.call_detect_mode) begin
      status_clr[`CALL_DETECT_BIT] = 1'b1;
    end
    // Software reset wipes all flags; live events re-arm them next cycle
    if (host_sw_reset_in) begin
      status_set = 8'h00;
      status_clr = 8'hFF;
    end
  end

  event_flag_bank #(
    .W(8)
  ) u_status_flags (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .set_in(status_set),
    .clr_in(status_clr),
    .flags_out(status_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sleep request mirrors on the controller side

  // Bits 5..1 follow host requests, bit 0 marks a return to working state
  always_comb begin
    mirror_set = 6'h00;
    mirror_clr = 6'h00;
    if (host_wr_req) begin
      mirror_set[5:1] = host_req_in.wdata[5:1];
      mirror_set[0] = (host_req_in.wdata[5:1] == 5'h00);
    end
    if (proc_wr_cs2) begin
      mirror_clr = proc_req_in.wdata[5:0];
    end
  end

  event_flag_bank #(
    .W(6)
  ) u_mirror_flags (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .set_in(mirror_set),
    .clr_in(mirror_clr),
    .flags_out(mirror_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexers

  // Host view; the request register is write-only in effect
  always_comb begin
    host_rd_mux = 8'h00;
    unique case (host_req_in.addr)
      `HOST_WAKE_STATUS_OFS: host_rd_mux = status_flags & `EVENT_BITS_MASK;
      `HOST_SLEEP_REQ_OFS: host_rd_mux = 8'h00;
      `HOST_SMI_EN_OFS: host_rd_mux = regs_q.smi_en;
      `HOST_IRQ_EN_OFS: host_rd_mux = regs_q.irq_en;
      default: host_rd_mux = 8'h00;
    endcase
  end

  // Controller view; misses and holes read as zero
  always_comb begin
    proc_rd_mux = 8'h00;
    if (proc_hit) begin
      unique case (proc_ofs)
        `PROC_CS1_OFS: proc_rd_mux = regs_q.cs1;
        `PROC_CS2_OFS: proc_rd_mux = {2'b00, mirror_flags};
        `PROC_CS3_OFS: proc_rd_mux = regs_q.cs3;
        `PROC_BASE_LO_OFS: proc_rd_mux = regs_q.base_lo;
        `PROC_BASE_HI_OFS: proc_rd_mux = regs_q.base_hi;
        `PROC_CIER_OFS: proc_rd_mux = regs_q.cier;
        `PROC_HSTAT_OFS: proc_rd_mux = regs_q.hstat;
        `PROC_HIER_OFS: proc_rd_mux = regs_q.hier;
        default: proc_rd_mux = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register next state

  always_comb begin
    regs_d = regs_q;
    // Host writes; reserved mask bits are never stored
    if (host_req_in.wr) begin
      unique case (host_req_in.addr)
        `HOST_SLEEP_REQ_OFS:
          regs_d.req = host_req_in.wdata & `SLEEP_REQ_MASK;
        `HOST_SMI_EN_OFS:
          regs_d.smi_en = host_req_in.wdata & `EVENT_BITS_MASK;
        `HOST_IRQ_EN_OFS:
          regs_d.irq_en = host_req_in.wdata & `EVENT_BITS_MASK;
        default: regs_d.req = regs_q.req;
      endcase
    end
    // Processor writes to plain storage registers
    if (proc_req_in.wr && proc_hit) begin
      unique case (proc_ofs)
        `PROC_CS1_OFS: regs_d.cs1 = proc_req_in.wdata;
        `PROC_CS3_OFS: regs_d.cs3 = proc_req_in.wdata;
        `PROC_BASE_LO_OFS: regs_d.base_lo = proc_req_in.wdata;
        `PROC_BASE_HI_OFS: regs_d.base_hi = proc_req_in.wdata;
        `PROC_CIER_OFS: regs_d.cier = proc_req_in.wdata;
        `PROC_HSTAT_OFS: regs_d.hstat = proc_req_in.wdata;
        `PROC_HIER_OFS: regs_d.hier = proc_req_in.wdata;
        default: regs_d.cs3 = regs_q.cs3;
      endcase
    end
    // Masks and host requests fall back to zero on a host software reset
    if (host_sw_reset_in) begin
      regs_d.smi_en = `REG_RESET;
      regs_d.irq_en = `REG_RESET;
      regs_d.req = `REG_RESET;
    end
    // Read data is captured on the strobe and held until the next one
    if (host_req_in.rd) begin
      regs_d.host_rdata = host_rd_mux;
    end
    if (proc_req_in.rd) begin
      regs_d.proc_rdata = proc_rd_mux;
    end
    // Registered outputs lag the flags by one cycle to stay glitch free;
    // mask bit 7 is plain storage, so the module event routes nowhere
    regs_d.smi_n = ~|(status_flags & regs_q.smi_en &
                      `ROUTE_BITS_MASK);
    regs_d.irq = |(status_flags & regs_q.irq_en &
                   `ROUTE_BITS_MASK);
  end

  // Power-up reset puts every register to its default
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      regs_q <= '0;
      regs_q.smi_n <= 1'b1;
    end else begin
      regs_q <= regs_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign host_rdata_out = regs_q.host_rdata;
  assign proc_rdata_out = regs_q.proc_rdata;
  assign system_mgmt_irq_n_out = regs_q.smi_n;
  assign wake_irq_out = regs_q.irq;

endmodule

// >>> wake_host_model.sv
// Host system and embedded processor driving the two register ports
`timescale 1ns/1ps
module wake_host_model (
  // Clock
  input wire logic core_clk_in,
  // Register ports
  output wake_ctl_pkg::host_bus_req_t host_req_out,
  output wake_ctl_pkg::proc_bus_req_t proc_req_out,
  input wire logic [7:0] host_rdata_in,
  input wire logic [7:0] proc_rdata_in
);
  import wake_ctl_pkg::*;
  // Idle buses until the first access
  initial begin
    host_req_out = '0;
    proc_req_out = '0;
  end
  // Host access; a released bus shows inverted address and data
  task automatic host_acc(input logic w, input logic [4:0] a,
      input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk_in);
    #1 host_req_out = '{w, !w, a, d};
    @(posedge core_clk_in);
    #1 host_req_out = '{1'b0, 1'b0, ~a, ~d};
    q = host_rdata_in;
  endtask
  // Processor access, same strobes
  task automatic proc_acc(input logic w, input logic [15:0] a,
      input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk_in);
    #1 proc_req_out = '{w, !w, a, d};
    @(posedge core_clk_in);
    #1 proc_req_out = '{1'b0, 1'b0, ~a, ~d};
    q = proc_rdata_in;
  endtask
endmodule

// >>> wake_regs_props.sv
// Port-level checks for the wake register block
`timescale 1ns/1ps
module wake_regs_props (
  // Clock and resets
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic host_sw_reset_in,
  // Register ports
  input wire wake_ctl_pkg::host_bus_req_t host_req_in,
  input wire logic [7:0] host_rdata_out,
  input wire wake_ctl_pkg::proc_bus_req_t proc_req_in,
  input wire logic [7:0] proc_rdata_out,
  // Wake outputs
  input wire logic system_mgmt_irq_n_out,
  input wire logic wake_irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////
  // Read strobes at one offset of each port
  sequence s_hrd(logic [4:0] a);
    host_req_in.rd && host_req_in.addr == a;
  endsequence
  sequence s_erd(logic [15:0] a);
    proc_req_in.rd && proc_req_in.addr == a;
  endsequence
  a_req_read_zero: assert property (
    s_hrd(5'h07) |=> host_rdata_out == 8'h00) else $error("req not 0");
  a_smi_rsvd_zero: assert property (
    s_hrd(5'h13) |=> (host_rdata_out & 8'h34) == 8'h00) else $error("smi");
  a_irq_rsvd_zero: assert property (
    s_hrd(5'h15) |=> (host_rdata_out & 8'h34) == 8'h00) else $error("irq");
  a_stat_rsvd_zero: assert property (
    s_hrd(5'h00) |=> (host_rdata_out & 8'h34) == 8'h00) else $error("st");
  a_sw_reset_quiet: assert property (
    host_sw_reset_in |-> ##2 system_mgmt_irq_n_out && !wake_irq_out)
    else $error("outputs after soft reset");
  a_rst_release: assert property (
    $rose(rst_n_in) |-> system_mgmt_irq_n_out && !wake_irq_out)
    else $error("outputs after reset");
  // Window of the processor view is 1400h to 141Fh
  a_proc_window: assert property (
    proc_req_in.rd && proc_req_in.addr[15:5] != 11'h0A0 |=>
    proc_rdata_out == 8'h00) else $error("outside window");
  a_mirror_top: assert property (
    s_erd(16'h1402) |=> proc_rdata_out[7:6] == 2'b00) else $error("mirror");
endmodule
